//--- core/bre_pkg.sv
// Shared constants and types of the buffer RAM edit engine
package bre_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_KEY = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DISPLAY = 8'h08;
  localparam logic [7:0] OFS_PEEK_ADDR = 8'h0C;
  localparam logic [7:0] OFS_PEEK_DATA = 8'h10;

  // Field positions in the readable registers
  localparam int STAT_BUSY = 4;
  localparam int STAT_REMOTE = 5;
  localparam int STAT_FMT_LSB = 8;
  localparam int DISP_DATA_LSB = 16;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Keystroke codes; codes below KEY_ENTER are hex digits
  localparam logic [4:0] KEY_ENTER = 5'h10;
  localparam logic [4:0] KEY_MINUS = 5'h11;
  localparam logic [4:0] KEY_DEL = 5'h12;
  localparam logic [4:0] KEY_MOV = 5'h13;
  localparam logic [4:0] KEY_INP = 5'h14;
  localparam logic [4:0] KEY_REM = 5'h15;

  // Blank fill values and field presets
  localparam logic [7:0] BLANK_LOW = 8'h00;
  localparam logic [7:0] BLANK_HIGH = 8'hFF;
  localparam logic [7:0] FMT_PRESET = 8'h00;
  localparam logic [7:0] CHAR7_MASK = 8'h7F;

  // Transfer format codes, two BCD digits
  localparam logic [7:0] FMT_DISPLAY = 8'h35;
  localparam logic [7:0] FMT_LIST8 = 8'h47;
  localparam logic [7:0] FMT_LIST16 = 8'h48;

  typedef enum logic [1:0] {
    FC_BAD,
    FC_SEQ,
    FC_ADDR,
    FC_DISP
  } bre_fclass_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEL_SA,
    ST_DEL_VIEW,
    ST_DEL_SHIFT,
    ST_MOV_DST,
    ST_MOV_SRC,
    ST_MOV_CNT,
    ST_MOV_RUN,
    ST_IN_FMT,
    ST_IN_SA,
    ST_IN_EA,
    ST_IN_OFS,
    ST_IN_POL,
    ST_IN_RUN,
    ST_REMOTE
  } bre_state_t;

  // Reception parser chosen from the format code
  function automatic bre_fclass_t bre_fclass(input logic [7:0] code);
    bre_fclass_t c;
    c = FC_BAD;
    case (code)
      8'h10, 8'h11, 8'h12, 8'h30, 8'h31, 8'h33, 8'h34, 8'h60,
      8'h70: c = FC_SEQ;
      8'h20, 8'h21, 8'h22, 8'h23, 8'h32, 8'h40, 8'h41, 8'h42,
      8'h43, 8'h44, 8'h45, 8'h46, 8'h80: c = FC_ADDR;
      FMT_DISPLAY: c = FC_DISP;
      default: c = FC_BAD;
    endcase
    return c;
  endfunction

endpackage

//--- core/bre_rx_fifo.sv
// Small valid/ready buffer for received serial records
`timescale 1ns/1ps
`default_nettype none
module bre_rx_fifo #(
  parameter int W = 25,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic in_ready;
  } bre_fifo_t;

  bre_fifo_t q, d;
  logic push, pop;

  assign in_ready = q.in_ready;
  assign out_valid = (q.cnt != '0);
  assign out_data = q.ent[q.rp];

  // Pointer and occupancy update; ready drops when the last slot fills
  always_comb begin
    d = q;
    push = in_valid && q.in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      d.ent[q.wp] = in_data;
      d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: d.cnt = q.cnt + 1'b1;
      2'b01: d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    d.in_ready = (d.cnt != FULL);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- core/bre_core.sv
// Buffer RAM edit engine: delete, move and serial input set-up
`timescale 1ns/1ps
`default_nettype none
module bre_core
  import bre_pkg::*;
#(
  parameter int AW = 16,
  parameter int BUS_AW = 8,
  parameter bit HAS_DISPLAY_LOAD = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [BUS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [BUS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Target chip family: high selects FF as blank
  input wire logic blank_is_ff,
  // Received serial records
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic [AW-1:0] rx_addr,
  input wire logic rx_eot
);
  localparam int RXW = AW + 9;
  localparam logic [AW-1:0] TOP = '1;
  localparam logic [AW-1:0] ZERO = '0;

  typedef struct packed {
    bre_state_t st;
    logic [AW-1:0] first_location_field;
    logic [AW-1:0] alt_field;
    logic [AW-1:0] copy_length_field;
    logic [AW-1:0] ptr;
    logic [7:0] fmt;
    logic [7:0] shown;
    logic neg;
    logic inv;
    logic disp;
    logic key_ev;
    logic [4:0] key;
    logic [AW-1:0] peek;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic w_have;
    logic [BUS_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bre_core_t;

  bre_core_t q, d;
  logic [7:0] mem [0:(1 << AW) - 1];
  logic ram_we;
  logic [AW-1:0] ram_wa;
  logic [7:0] ram_wd;
  logic rx_out_valid, rx_pop;
  logic [RXW-1:0] rx_word;
  logic [7:0] rec_data;
  logic [AW-1:0] rec_addr;
  logic rec_eot;
  logic busy;

  // Records cross a two-entry buffer so a stalled engine loses none
  bre_rx_fifo #(
    .W(RXW),
    .DEPTH(2)
  ) u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_eot, rx_addr, rx_data}),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_word)
  );

  assign rx_pop = (q.st == ST_IN_RUN);
  assign rec_data = rx_word[7:0];
  assign rec_addr = rx_word[AW+7:8];
  assign rec_eot = rx_word[RXW-1];
  assign busy = (q.st == ST_DEL_SHIFT) || (q.st == ST_MOV_RUN);

  // Bus outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // Address shown by the display for the field being edited
  function automatic logic [AW-1:0] disp_addr(input bre_core_t s);
    logic [AW-1:0] a;
    a = s.first_location_field;
    case (s.st)
      ST_MOV_SRC, ST_IN_EA: a = s.alt_field;
      ST_MOV_CNT, ST_IN_OFS: a = s.copy_length_field;
      ST_IN_FMT, ST_IN_POL, ST_IN_RUN: a = AW'(s.fmt);
      default: a = s.first_location_field;
    endcase
    return a;
  endfunction

  // Buffer RAM write port, one byte per cycle
  always_ff @(posedge aclk) begin
    if (ram_we) begin
      mem[ram_wa] <= ram_wd;
    end
  end

  always_comb begin
    logic [AW-1:0] upper;
    logic [AW-1:0] rx_loc;
    logic [7:0] blank;
    logic dig;
    logic [3:0] nib;
    logic [31:0] rd;
    logic rd_ok;
    d = q;
    d.key_ev = 1'b0;
    ram_we = 1'b0;
    ram_wa = ZERO;
    ram_wd = BLANK_LOW;
    upper = q.ptr + 1'b1;
    rx_loc = q.neg ? rec_addr - q.copy_length_field :
                     rec_addr + q.copy_length_field;
    blank = blank_is_ff ? BLANK_HIGH : BLANK_LOW;
    dig = (q.key < KEY_ENTER);
    nib = q.key[3:0];
    rd = 32'h0;
    rd_ok = 1'b1;

    // Block operations that run one byte per cycle
    case (q.st)
      ST_DEL_SHIFT: begin
        ram_we = 1'b1;
        if (q.ptr == TOP) begin
          ram_wa = TOP;
          ram_wd = blank;
          d.st = ST_DEL_VIEW;
        end else begin
          ram_wa = q.ptr;
          ram_wd = mem[upper];
          d.ptr = upper;
        end
      end
      ST_MOV_RUN: begin
        ram_we = 1'b1;
        ram_wa = q.first_location_field + q.ptr;
        ram_wd = mem[q.alt_field + q.ptr];
        d.ptr = upper;
        if (upper == q.copy_length_field) begin
          d.st = ST_IDLE;
        end
      end
      ST_IN_RUN: begin
        if (rx_out_valid) begin
          if (rec_eot) begin
            d.st = ST_IDLE;
          end else if (q.disp) begin
            d.shown = rec_data & CHAR7_MASK;
          end else if (bre_fclass(q.fmt) == FC_ADDR) begin
            ram_we = 1'b1;
            ram_wa = rx_loc;
            ram_wd = q.inv ? ~rec_data : rec_data;
          end else begin
            ram_we = 1'b1;
            ram_wa = q.ptr;
            ram_wd = q.inv ? ~rec_data : rec_data;
            d.ptr = upper;
            if (q.ptr == q.alt_field) begin
              d.st = ST_IDLE;
            end
          end
        end
      end
      default: begin
      end
    endcase

    // Keystroke handling
    if (q.key_ev) begin
      if (q.st == ST_REMOTE) begin
        if (q.key == KEY_REM) begin
          d.st = ST_IDLE;
        end
      end else if (q.key == KEY_REM) begin
        d.st = ST_REMOTE;
      end else if (q.key == KEY_DEL) begin
        d.st = ST_DEL_SA;
        d.first_location_field = ZERO;
      end else if (q.key == KEY_MOV) begin
        d.st = ST_MOV_DST;
        d.first_location_field = ZERO;
      end else if (q.key == KEY_INP) begin
        d.st = ST_IN_FMT;
        d.fmt = FMT_PRESET;
        d.disp = 1'b0;
      end else begin
        case (q.st)
          ST_DEL_SA: begin
            if (dig) begin
              d.first_location_field =
                {q.first_location_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER) begin
              d.st = ST_DEL_VIEW;
            end
          end
          ST_DEL_VIEW: begin
            if (q.key == KEY_ENTER) begin
              d.st = ST_DEL_SHIFT;
              d.ptr = q.first_location_field;
            end
          end
          ST_MOV_DST: begin
            if (dig) begin
              d.first_location_field =
                {q.first_location_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER) begin
              d.st = ST_MOV_SRC;
              d.alt_field = ZERO;
            end
          end
          ST_MOV_SRC: begin
            if (dig) begin
              d.alt_field = {q.alt_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER) begin
              d.st = ST_MOV_CNT;
              d.copy_length_field = ZERO;
            end
          end
          ST_MOV_CNT: begin
            if (dig) begin
              d.copy_length_field = {q.copy_length_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER) begin
              d.ptr = ZERO;
              d.st = (q.copy_length_field == ZERO) ? ST_IDLE :
                                                     ST_MOV_RUN;
            end
          end
          ST_IN_FMT: begin
            if (dig) begin
              d.fmt = {q.fmt[3:0], nib};
            end else if (q.key == KEY_ENTER) begin
              case (bre_fclass(q.fmt))
                FC_SEQ: begin
                  d.st = ST_IN_SA;
                  d.first_location_field = ZERO;
                end
                FC_ADDR: begin
                  d.st = ST_IN_OFS;
                  d.copy_length_field = ZERO;
                end
                FC_DISP: begin
                  if (HAS_DISPLAY_LOAD) begin
                    d.st = ST_IN_RUN;
                    d.disp = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
          ST_IN_SA: begin
            if (dig) begin
              d.first_location_field =
                {q.first_location_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER) begin
              d.st = ST_IN_EA;
              d.alt_field = ZERO;
            end
          end
          ST_IN_EA: begin
            if (dig) begin
              d.alt_field = {q.alt_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER) begin
              d.st = ST_IN_POL;
              d.ptr = q.first_location_field;
            end
          end
          ST_IN_OFS: begin
            if (dig) begin
              d.copy_length_field = {q.copy_length_field[AW-5:0], nib};
            end else if (q.key == KEY_ENTER || q.key == KEY_MINUS) begin
              d.st = ST_IN_POL;
              d.neg = (q.key == KEY_MINUS);
            end
          end
          ST_IN_POL: begin
            if (q.key == KEY_ENTER || q.key == KEY_MINUS) begin
              d.st = ST_IN_RUN;
              d.inv = (q.key == KEY_MINUS);
            end
          end
          default: begin
          end
        endcase
      end
      if (q.key == KEY_INP || q.key == KEY_DEL || q.key == KEY_MOV) begin
        d.neg = 1'b0;
        d.inv = 1'b0;
      end
    end

    // Fixed address, byte now standing there
    if (d.st == ST_DEL_VIEW && !ram_we) begin
      d.shown = mem[q.first_location_field];
    end

    // Write channel: address and data taken in either order
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case ({d.waddr[BUS_AW-1:2], 2'b00})
        BUS_AW'(OFS_KEY): begin
          if (d.wstrb[0] && !busy) begin
            d.key_ev = 1'b1;
            d.key = d.wdata[4:0];
          end
        end
        BUS_AW'(OFS_PEEK_ADDR): begin
          if (d.wstrb[0]) begin
            d.peek[7:0] = d.wdata[7:0];
          end
          if (d.wstrb[1]) begin
            d.peek[AW-1:8] = d.wdata[AW-1:8];
          end
        end
        BUS_AW'(OFS_STATUS), BUS_AW'(OFS_DISPLAY),
        BUS_AW'(OFS_PEEK_DATA): begin
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    // Read channel: one answer at a time
    case ({s_axi_araddr[BUS_AW-1:2], 2'b00})
      BUS_AW'(OFS_KEY): rd[4:0] = q.key;
      BUS_AW'(OFS_STATUS): begin
        rd[3:0] = q.st;
        rd[STAT_BUSY] = busy;
        rd[STAT_REMOTE] = (q.st == ST_REMOTE);
        rd[STAT_FMT_LSB +: 8] = q.fmt;
      end
      BUS_AW'(OFS_DISPLAY): begin
        rd[AW-1:0] = disp_addr(q);
        rd[DISP_DATA_LSB +: 8] = q.shown;
      end
      BUS_AW'(OFS_PEEK_ADDR): rd[AW-1:0] = q.peek;
      BUS_AW'(OFS_PEEK_DATA): rd[7:0] = mem[q.peek];
      default: rd_ok = 1'b0;
    endcase
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- test/bre_core_asserts.sv
// Bus and record port checker for the edit engine
`timescale 1ns/1ps
`default_nettype none
module bre_core_asserts
  import bre_pkg::*;
#(
  parameter int BUS_AW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [BUS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [BUS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Record stream
  input wire logic rx_ready
);
  // True for the five decoded offsets
  function automatic logic is_mapped(input logic [BUS_AW-1:0] a);
    return a == OFS_KEY || a == OFS_STATUS || a == OFS_DISPLAY ||
      a == OFS_PEEK_ADDR || a == OFS_PEEK_DATA;
  endfunction

  // Pending write hit a hole in the map
  logic aw_bad_q;
  logic aw_bad_d;
  always_comb begin
    aw_bad_d = aw_bad_q;
    if (s_axi_awvalid && s_axi_awready) aw_bad_d = !is_mapped(s_axi_awaddr);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) aw_bad_q <= 1'b0;
    else aw_bad_q <= aw_bad_d;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Steps of the bus transfers
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_status_read;
    s_read_taken ##0 s_axi_araddr == OFS_STATUS;
  endsequence

  AST_B_AFTER_AW_W: assert property (s_both_taken |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_BLOCKS_W: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  AST_W_RESP_CODE: assert property (s_axi_bvalid |->
    s_axi_bresp == (aw_bad_q ? RESP_SLVERR : RESP_OKAY))
    else $error("wrong write response code");
  AST_R_AFTER_AR: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  AST_R_BLOCKS_AR: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  AST_R_UNMAPPED: assert property (s_read_taken ##0
    !is_mapped(s_axi_araddr) |=> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_R_MAPPED: assert property (s_read_taken ##0 is_mapped(s_axi_araddr)
    |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  AST_REMOTE_FLAG: assert property (s_status_read |=>
    s_axi_rdata[STAT_REMOTE] == (s_axi_rdata[3:0] == ST_REMOTE))
    else $error("remote flag disagrees with state");
  AST_QUIET_AFTER_RESET: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !rx_ready && !s_axi_awready)
    else $error("handshake active straight after reset");
endmodule
`default_nettype wire

//--- test/bre_rx_host.sv
// Serial host model that feeds received records to the engine
`timescale 1ns/1ps
`default_nettype none
module bre_rx_host (
  // Clock and handshake return
  input wire logic aclk,
  input wire logic rx_ready,
  // Record lines
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic [15:0] rx_addr,
  output logic rx_eot
);
  int gap = 0;

  // Idle lines until the first record
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_addr = 16'h0000;
    rx_eot = 1'b0;
  end

  // One record, held until taken; lines scrambled once released
  task automatic send(input logic [7:0] d, input logic [15:0] a,
                      input logic e);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_addr <= a;
    rx_eot <= e;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_addr <= ~a;
    rx_eot <= ~e;
  endtask
endmodule
`default_nettype wire

//--- test/test_bre_core.sv
// Self-checking bench for the buffer RAM edit engine
`timescale 1ns/1ps
`default_nettype none
module test_bre_core
  import bre_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, blank_ff = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic rx_valid, rx_ready, rx_eot;
  logic [7:0] rx_data;
  logic [15:0] rx_addr;
  int error_cnt = 0;
  int checked = 0;

  // 25 MHz clock
  always #20 aclk = ~aclk;

  bre_core dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .blank_is_ff(blank_ff), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_addr(rx_addr),
    .rx_eot(rx_eot));

  bre_rx_host host (.aclk(aclk), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_addr(rx_addr),
    .rx_eot(rx_eot));

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Bus write: address and data together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (i == 99) error_cnt++;
    end
  endtask

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    r = 2'h3;
    d = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        r = rresp;
        d = rdata;
        rready <= 1'b0;
        break;
      end
      if (i == 99) error_cnt++;
    end
  endtask

  task automatic key(input logic [4:0] k);
    logic [1:0] r;
    wr(OFS_KEY, {27'h0, k}, r);
    chk("key response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // Four hex digits, most significant first
  task automatic hex(input logic [15:0] v);
    for (int i = 3; i >= 0; i--) key({1'b0, v[i*4 +: 4]});
  endtask

  task automatic status(input logic [3:0] st);
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_STATUS, d, r);
    chk("state", {28'h0, st}, {28'h0, d[3:0]});
  endtask

  task automatic disp(input logic [23:0] e, input logic [23:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_DISPLAY, d, r);
    chk("display", {8'h0, e & m}, {8'h0, d[23:0] & m});
  endtask

  task automatic peek(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_PEEK_ADDR, {16'h0, a}, r);
    rd(OFS_PEEK_DATA, d, r);
    chk("ram byte", {24'h0, e}, {24'h0, d[7:0]});
  endtask

  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 200; i++) begin
      rd(OFS_STATUS, d, r);
      if (d[STAT_BUSY] === 1'b0) break;
    end
  endtask

  task automatic mv(input logic [15:0] dst, src, cnt);
    key(KEY_MOV);
    disp(24'h0, 24'h00FFFF);
    hex(dst);
    key(KEY_ENTER);
    disp(24'h0, 24'h00FFFF);
    hex(src);
    key(KEY_ENTER);
    status(ST_MOV_CNT);
    hex(cnt);
    key(KEY_ENTER);
    wait_idle();
    status(ST_IDLE);
  endtask

  task automatic s_input_seq;
    key(KEY_INP);
    disp(24'h0, 24'h0000FF);
    key(KEY_ENTER);
    status(ST_IN_FMT);
    hex(16'h0010);
    key(KEY_ENTER);
    status(ST_IN_SA);
    hex(16'hFFFC);
    key(KEY_ENTER);
    hex(16'hFFFF);
    key(KEY_ENTER);
    status(ST_IN_POL);
    key(KEY_ENTER);
    for (int i = 0; i < 4; i++) host.send(8'hA1 + 8'h11 * i, 16'h1234, 1'b0);
    status(ST_IDLE);
    for (int i = 0; i < 4; i++) peek(16'hFFFC + i, 8'hA1 + 8'h11 * i);
  endtask

  task automatic s_delete;
    @(posedge aclk);
    blank_ff <= 1'b1;
    key(KEY_DEL);
    disp(24'h0, 24'h00FFFF);
    hex(16'hFFFC);
    key(KEY_ENTER);
    disp(24'hA1FFFC, 24'hFFFFFF);
    key(KEY_ENTER);
    wait_idle();
    disp(24'hB2FFFC, 24'hFFFFFF);
    peek(16'hFFFF, 8'hFF);
    @(posedge aclk);
    blank_ff <= 1'b0;
    key(KEY_ENTER);
    wait_idle();
    disp(24'hC3FFFC, 24'hFFFFFF);
    peek(16'hFFFD, 8'hD4);
    peek(16'hFFFE, 8'hFF);
    peek(16'hFFFF, 8'h00);
  endtask

  task automatic s_remote;
    key(KEY_REM);
    status(ST_REMOTE);
    key(KEY_DEL);
    status(ST_REMOTE);
    key(KEY_REM);
    status(ST_IDLE);
  endtask

  task automatic s_move;
    mv(16'hFFF0, 16'hFFFC, 16'h0002);
    peek(16'hFFF1, 8'hD4);
    peek(16'hFFFD, 8'hD4);
    mv(16'hFFFD, 16'hFFFC, 16'h0002);
    peek(16'hFFFE, 8'hC3);
    mv(16'hFFF0, 16'hFFFF, 16'h0000);
    peek(16'hFFF0, 8'hC3);
  endtask

  task automatic addr_run(input logic [15:0] fmt, ofs,
                          input logic [4:0] close, pol,
                          input logic [7:0] d, input logic [15:0] a);
    key(KEY_INP);
    hex(fmt);
    key(KEY_ENTER);
    status(ST_IN_OFS);
    hex(ofs);
    key(close);
    status(ST_IN_POL);
    key(pol);
    status(ST_IN_RUN);
    host.send(d, a, 1'b0);
    host.send(8'h00, 16'h0000, 1'b1);
    status(ST_IDLE);
  endtask

  task automatic s_input_addr;
    addr_run(16'h0023, 16'h0100, KEY_MINUS, KEY_MINUS, 8'h5A, 16'h01F0);
    peek(16'h00F0, 8'hA5);
    host.gap = 3;
    addr_run(16'h0040, 16'h0010, KEY_ENTER, KEY_ENTER, 8'h77, 16'h0100);
    peek(16'h0110, 8'h77);
    host.gap = 0;
  endtask

  task automatic s_refuse;
    key(KEY_INP);
    hex(16'h0047);
    key(KEY_ENTER);
    status(ST_IN_FMT);
    hex(16'h0048);
    key(KEY_ENTER);
    status(ST_IN_FMT);
  endtask

  // Buffer filled while the engine waits in ST_IN_FMT, drained in display mode
  task automatic s_display;
    host.send(8'hC1, 16'h0000, 1'b0);
    host.send(8'hC2, 16'h0000, 1'b0);
    @(posedge aclk);
    chk("rx ready", 32'h0, {31'h0, rx_ready});
    fork
      host.send(8'hC3, 16'h0000, 1'b0);
    join_none
    key(KEY_INP);
    hex(16'h0035);
    key(KEY_ENTER);
    status(ST_IN_RUN);
    wait fork;
    disp(24'h430000, 24'hFF0000);
    host.send(8'h00, 16'h0000, 1'b1);
    status(ST_IDLE);
  endtask

  task automatic s_bus_err;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h40, 32'h0, r);
    chk("write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(8'h44, d, r);
    chk("read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("read data", 32'h0, d);
  endtask

  task automatic s_reset;
    key(KEY_MOV);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    status(ST_IDLE);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_input_seq();
    s_delete();
    s_remote();
    s_move();
    s_input_addr();
    s_refuse();
    s_display();
    s_bus_err();
    s_reset();
    test_done();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    $display("[ERR] run length expected done seen timeout");
    test_done();
  end
endmodule

bind bre_core bre_core_asserts #(.BUS_AW(BUS_AW)) u_asserts (.*);
`default_nettype wire
